// >>> rtf_map.svh
// Constants for the relay toggle and flasher logic.
// Assumes a 100 MHz clock; timing counts are derived from the figures here.
`ifndef RTF_MAP_SVH
`define RTF_MAP_SVH
`define RTF_CLK_HZ 100000000
`define RTF_DEBOUNCE_MS 20
`define RTF_DEBOUNCE_CYC ((`RTF_DEBOUNCE_MS * (`RTF_CLK_HZ / 1000)))
`define RTF_FLASH_PER_MIN 90
`define RTF_FLASH_HALF_CYC ((`RTF_CLK_HZ / `RTF_FLASH_PER_MIN) * 60 / 2)
`define RTF_MODE_TOGGLE 1'b0
`define RTF_MODE_FLASH 1'b1
`endif

// >>> rtf_pkg.sv
// Types shared by the relay toggle and flasher logic.
// Assumes rtf_map.svh supplies the constants.
package rtf_pkg;
  typedef enum logic {RTF_EDGE_RISE, RTF_EDGE_FALL} rtf_edge_t;
  typedef struct packed {
    logic relay_on;
    logic inverted_aux_output;
  } rtf_out_t;
endpackage : rtf_pkg

// >>> rtf_debounce.sv
// Synchroniser and debounce filter for the ignition terminal line.
// Assumes a raw pin input from outside the clock domain.
`timescale 1ns/10ps
module rtf_debounce #(
  parameter int unsigned CYCLES = 2000000
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin,
  output logic level
);
  generate
    if (CYCLES < 1) begin : g_cyc_chk
      $error("Debounce count must be at least one.");
    end
  endgenerate
  logic s1_q, s2_q, lvl_q, lvl_d;
  logic [31:0] cnt_q, cnt_d;
  always_comb begin
    lvl_d = lvl_q;
    cnt_d = 32'h0;
    if (s2_q != lvl_q) begin
      if (cnt_q >= CYCLES - 1) begin
        lvl_d = s2_q;
      end else begin
        cnt_d = cnt_q + 32'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      lvl_q <= 1'b0;
      cnt_q <= 32'h0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end
  assign level = lvl_q;
endmodule : rtf_debounce

// >>> rtf_relay.sv
// Operation
// - Toggle mode: each accepted impulse flips relay.
// - Input debounced; one impulse per press.
// - Rising or falling edge variant selectable.
// - Falling variant: power-up counts as edge.
// - Flasher starts pulsing immediately on input.
// - Flasher rate 90 per minute nominal.
// - Aux output is inverted input in flasher.
//
// Top of the relay toggle and flasher logic.
// Assumes one 100 MHz clock and a raw ignition pin with two-stage sync.
`timescale 1ns/10ps
`include "rtf_map.svh"
module rtf_relay #(
  parameter int unsigned DEBOUNCE_CYC = `RTF_DEBOUNCE_CYC,
  parameter int unsigned FLASH_HALF_CYC = `RTF_FLASH_HALF_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ignition_terminal_line,
  input wire logic flash_mode,
  input wire rtf_pkg::rtf_edge_t edge_sel,
  output rtf_pkg::rtf_out_t relay_out
);
  import rtf_pkg::*;

  // Elaboration checks on the timing parameters.
  generate
    if (DEBOUNCE_CYC < 1) begin : g_deb_chk
      $error("Debounce count must be at least one.");
    end
    if (FLASH_HALF_CYC < 1) begin : g_half_chk
      $error("Flash half period must be at least one.");
    end
  endgenerate

  // True when the level moved in the selected direction.
  function automatic logic edge_seen(
    input logic now_lvl,
    input logic was_lvl,
    input rtf_edge_t dir
  );
    logic hit;
    if (dir == RTF_EDGE_RISE) begin
      hit = now_lvl & ~was_lvl;
    end else begin
      hit = ~now_lvl & was_lvl;
    end
    return hit;
  endfunction : edge_seen

  // True when a counter has reached the last cycle of its span.
  function automatic logic count_done(
    input logic [31:0] count,
    input int unsigned span
  );
    logic done;
    done = (count >= span - 32'h1);
    return done;
  endfunction : count_done

  // Filtered input level and synchronised mode strap.
  logic in_lvl;
  logic mode_s1_q, mode_s1_d;
  logic mode_s2_q, mode_s2_d;

  // Edge detection and power-up marker.
  logic prev_q, prev_d;
  logic pwr_q, pwr_d;
  logic tog_hit;
  logic fl_start;

  // Relay state for both behaviours.
  logic tog_q, tog_d;
  logic fl_q, fl_d;
  logic [31:0] fcnt_q, fcnt_d;
  logic relay_q, relay_d;
  logic aux_q, aux_d;

  // Raw pin passes two flops and the bounce filter before use.
  rtf_debounce #(
    .CYCLES(DEBOUNCE_CYC)
  ) u_deb (
    .clock(clock),
    .resetn(resetn),
    .pin(ignition_terminal_line),
    .level(in_lvl)
  );

  // Mode strap synchroniser; only the second stage feeds the logic.
  always_comb begin
    mode_s1_d = flash_mode;
    mode_s2_d = mode_s1_q;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      mode_s1_q <= mode_s1_d;
      mode_s2_q <= mode_s2_d;
    end
  end

  // Edge detection on the filtered level.
  always_comb begin
    prev_d = in_lvl;
    tog_hit = edge_seen(in_lvl, prev_q, edge_sel);
    fl_start = edge_seen(in_lvl, prev_q, RTF_EDGE_RISE);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // The power flag is low for one cycle after reset; the falling variant sees an edge there.
  always_comb begin
    pwr_d = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Toggle state holds until the next accepted edge.
  always_comb begin
    tog_d = tog_q;
    if (tog_hit || (edge_sel == RTF_EDGE_FALL && !pwr_q)) begin
      tog_d = ~tog_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end

  // Flasher phase starts on at activation and is forced off when idle.
  always_comb begin
    fl_d = fl_q;
    if (!in_lvl) begin
      fl_d = 1'b0;
    end else if (fl_start) begin
      fl_d = 1'b1;
    end else if (count_done(fcnt_q, FLASH_HALF_CYC)) begin
      fl_d = ~fl_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      fl_q <= 1'b0;
    end else begin
      fl_q <= fl_d;
    end
  end

  // Half period counter; it restarts at activation, at each phase change and while idle.
  always_comb begin
    fcnt_d = fcnt_q + 32'h1;
    if (!in_lvl || fl_start || count_done(fcnt_q, FLASH_HALF_CYC)) begin
      fcnt_d = 32'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      fcnt_q <= 32'h0;
    end else begin
      fcnt_q <= fcnt_d;
    end
  end

  // Relay drive follows the behaviour chosen by the synchronised strap.
  always_comb begin
    relay_d = tog_d;
    if (mode_s2_q == `RTF_MODE_FLASH) begin
      relay_d = fl_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      relay_q <= 1'b0;
    end else begin
      relay_q <= relay_d;
    end
  end

  // The aux line follows the inverted input only in flasher mode.
  always_comb begin
    aux_d = 1'b0;
    if (mode_s2_q == `RTF_MODE_FLASH) begin
      aux_d = ~in_lvl;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      aux_q <= 1'b0;
    end else begin
      aux_q <= aux_d;
    end
  end

  // Both outputs leave as one registered carrier.
  always_comb begin
    relay_out.relay_on = relay_q;
    relay_out.inverted_aux_output = aux_q;
  end
endmodule : rtf_relay

// >>> rtf_relay_chk.sv
// Checker for rtf_relay.
// Assumes DEBOUNCE_CYC 4 and FLASH_HALF_CYC 8.
`timescale 1ns/10ps
module rtf_relay_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ignition_terminal_line,
  input wire logic flash_mode,
  input wire rtf_pkg::rtf_edge_t edge_sel,
  input wire rtf_pkg::rtf_out_t relay_out
);
  wire p = ignition_terminal_line;
  wire f = flash_mode;
  wire r = relay_out.relay_on;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_HOLD: assert property ((!f && $stable(p))[*8] |=> $stable(r)) else $error("hold");
  AST_EDGE: assert property ((!f && p == edge_sel)[*8] ##1 (!f && p != edge_sel)[*8]
    ##1 (!f && p != edge_sel)[*2] |-> r != $past(r, 10)) else $error("edge");
  AST_PWR: assert property ($rose(resetn) && !f && edge_sel |-> ##[1:3] r) else $error("pwr");
  AST_START: assert property ((f && !p)[*8] ##1 (f && p)[*8] ##1 (f && p)[*2] |-> r)
    else $error("start");
  AST_LOW: assert property ((f && p)[*8] ##0 $fell(r) |=> !r[*7]) else $error("low");
  AST_AUX: assert property ((f && $stable(p))[*8] ##1 (f && $stable(p))[*2]
    |-> relay_out.inverted_aux_output == !p) else $error("aux");
endmodule : rtf_relay_chk
bind rtf_relay rtf_relay_chk CHK (.*);

// >>> rtf_button.sv
// Push-button model; it bounces on release only.
// Assumes presses are spaced well beyond the few bounce cycles.
`timescale 1ns/10ps
module rtf_button (
  input wire logic clock,
  input wire logic want,
  output logic pin = 1'b0
);
  always @(want) begin
    repeat (want ? 0 : $urandom % 3) begin
      @(posedge clock) #1 pin = 1'b0;
      @(posedge clock) #1 pin = 1'b1;
    end
    @(posedge clock) #1 pin = want;
  end
endmodule : rtf_button

// >>> rtf_relay_tb.sv
// Testbench for rtf_relay.
`timescale 1ns/10ps
module rtf_relay_tb;
  import rtf_pkg::*;
  logic clock = 0, resetn = 0, want = 0, flash_mode = 0, pin;
  rtf_edge_t edge_sel = RTF_EDGE_RISE;
  rtf_out_t relay_out;
  int errors = 0, n_compared = 0, cyc = 0, n, hi, tg, pv;
  rtf_button BTN (.clock(clock), .want(want), .pin(pin));
  rtf_relay #(.DEBOUNCE_CYC(4), .FLASH_HALF_CYC(8)) DUT (.clock(clock), .resetn(resetn),
    .ignition_terminal_line(pin), .flash_mode(flash_mode), .edge_sel(edge_sel),
    .relay_out(relay_out));
  initial forever #5 clock = !clock;
  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %h %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic exp_toggle(input int presses, input int fall);
    return 1'(presses + fall);
  endfunction : exp_toggle
  task automatic give_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic run(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : run
  always @(posedge clock) if (++cyc == 3000) begin
    errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(21));
    for (int e = 0; e < 2; e++) begin
      edge_sel = rtf_edge_t'(e);
      resetn = 0;
      run(16);
      resetn = 1;
      run(4);
      chk(relay_out.relay_on, exp_toggle(0, e));
      n = 2 + $urandom % 4;
      for (int i = 0; i < n; i++) begin
        want = 1;
        run(20 + $urandom % 9);
        want = 0;
        run(20 + $urandom % 9);
        chk(relay_out.relay_on, exp_toggle(i + 1, e));
      end
    end
    flash_mode = 1;
    run(20);
    chk(relay_out.inverted_aux_output, 1'b1);
    want = 1;
    run(20);
    chk(relay_out.inverted_aux_output, 1'b0);
    hi = 0;
    tg = 0;
    pv = relay_out.relay_on;
    repeat (64) begin
      run(1);
      hi += relay_out.relay_on;
      tg += (relay_out.relay_on != pv);
      pv = relay_out.relay_on;
    end
    chk(hi == 32, 1'b1);
    chk(tg == 8, 1'b1);
    want = 0;
    run(20);
    chk(relay_out.relay_on, 1'b0);
    give_verdict();
  end
endmodule : rtf_relay_tb
